// ===== src/bis_pkg.sv
// package for the burner ignition sequencer: states, timing, register map
// Summary of operation
// - independent process output follows its demand in every state unless diagnostic mode selected.
// - after reset in automatic mode the sequencer sits in stopped.
// - stop key forces stopped from every state except alarm states.
// - release of qualified ok goes to start-up, or idle when on demand.
// - stopped closes every valve but the independent process one and asserts the alarm output.
// - start-up checks closure proof; active gives closure fault, else pre-purge.
// - pre-purge reloads ignition retries, waits pre-purge time, then ignite.
// - ignite drives igniter, opens shutdown and pilot valves for ignition time.
// - flame sensed during ignite moves to establish pilot.
// - ignition time expiring without flame moves to purge.
// - purge closes valves; retries left wait purge time then ignite, else wait.
// - wait closes valves; wait retries left wait then pre-purge, else pilot fault.
// - establish pilot needs steady flame all duration; loss reloads, goes ignite.
// - pilot on goes active when a process is active; flame loss relights.
// - idle closes valves, waits for demand with no limit, then start-up.
// - on demand lights the pilot only when some process needs flame.
// - active state opens each demanded process valve; one state serves every set.
package bis_pkg;
  localparam int BIS_CLK_HZ = 100_000_000;
  localparam int BIS_TICK_S = 1;
  localparam int BIS_TICK_CYC = BIS_CLK_HZ * BIS_TICK_S;
  localparam int BIS_OKHOLD_S = 1;
  localparam int BIS_TW = 16;
  localparam int BIS_RW = 8;
  localparam int BIS_NPRC = 3;
  // apb byte offsets
  localparam logic [7:0] BIS_A_CTRL = 8'h00;
  localparam logic [7:0] BIS_A_PRE = 8'h04;
  localparam logic [7:0] BIS_A_IGN = 8'h08;
  localparam logic [7:0] BIS_A_PRG = 8'h0c;
  localparam logic [7:0] BIS_A_WAIT = 8'h10;
  localparam logic [7:0] BIS_A_PEST = 8'h14;
  localparam logic [7:0] BIS_A_RTRY = 8'h18;
  localparam logic [7:0] BIS_A_STAT = 8'h1c;
  // ctrl fields
  localparam int BIS_C_ONDEM = 0;
  localparam int BIS_C_DIAG = 1;
  // reset values of durations (seconds) and retries
  localparam logic [BIS_TW-1:0] BIS_PRE_RST = 16'h003c;
  localparam logic [BIS_TW-1:0] BIS_IGN_RST = 16'h000a;
  localparam logic [BIS_TW-1:0] BIS_PRG_RST = 16'h001e;
  localparam logic [BIS_TW-1:0] BIS_WAIT_RST = 16'h012c;
  localparam logic [BIS_TW-1:0] BIS_PEST_RST = 16'h000a;
  localparam logic [BIS_RW-1:0] BIS_IRTY_RST = 8'h03;
  localparam logic [BIS_RW-1:0] BIS_WRTY_RST = 8'h03;

  typedef enum logic [3:0] {
    BIS_STOP = 4'h0,
    BIS_START = 4'h1,
    BIS_PRE = 4'h3,
    BIS_IGN = 4'h2,
    BIS_PEST = 4'h6,
    BIS_PON = 4'h7,
    BIS_ACT = 4'h5,
    BIS_PRG = 4'h4,
    BIS_WAIT = 4'hc,
    BIS_IDLE = 4'hd,
    BIS_POCF = 4'hf,
    BIS_PLTF = 4'he
  } bis_state_t;

  typedef struct packed {
    logic emergency_shutdown_valve;
    logic pilot;
    logic igniter;
    logic [BIS_NPRC-1:0] prc;
    logic alarm;
  } bis_out_t;
endpackage

// ===== src/bis_sequencer.sv
// burner ignition sequencer with apb configuration registers
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module bis_sequencer #(
  parameter int TICK_CYC = bis_pkg::BIS_TICK_CYC
) (
  input wire logic clk_i, // 100 mhz clock
  input wire logic arst_n_i, // async reset, low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic flame_i, // flame sensed (pin)
  input wire logic closure_proof_input_i, // closure proof active (pin)
  input wire logic [2:0] demand_i, // process demand (pins)
  input wire logic indep_demand_i, // independent process demand (pin)
  input wire logic key_ok_i, // ok key (pin)
  input wire logic key_stop_i, // stop key (pin)
  input wire logic start_sel_i, // start menu entry selected
  input wire logic alarm_state_i, // alarm handling owns the sequencer
  output bis_pkg::bis_out_t outs_o, // valve, igniter, alarm drive
  output logic independent_process_o, // independent process valve
  output bis_pkg::bis_state_t state_o // current state
);
  import bis_pkg::*;

  // two-flop synchronisers for pins
  logic [7:0] sy1_r, sy2_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sy1_r <= 8'h00;
      sy2_r <= 8'h00;
    end else begin
      sy1_r <= {flame_i, closure_proof_input_i, demand_i, indep_demand_i,
                key_ok_i, key_stop_i};
      sy2_r <= sy1_r;
    end
  end
  logic flame, poc, indep, ok, stop;
  logic [2:0] dem;
  assign flame = sy2_r[7];
  assign poc = sy2_r[6];
  assign dem = sy2_r[5:3];
  assign indep = sy2_r[2];
  assign ok = sy2_r[1];
  assign stop = sy2_r[0];

  // configuration registers
  logic ondem_r, diag_r;
  logic [BIS_TW-1:0] pre_r, ign_r, prg_r, wait_r, pest_r;
  logic [BIS_RW-1:0] irty_cfg_r, wrty_cfg_r;
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ondem_r <= 1'b0;
      diag_r <= 1'b0;
      pre_r <= BIS_PRE_RST;
      ign_r <= BIS_IGN_RST;
      prg_r <= BIS_PRG_RST;
      wait_r <= BIS_WAIT_RST;
      pest_r <= BIS_PEST_RST;
      irty_cfg_r <= BIS_IRTY_RST;
      wrty_cfg_r <= BIS_WRTY_RST;
    end else if (wr) begin
      case (paddr_i)
        BIS_A_CTRL: begin
          ondem_r <= pwdata_i[BIS_C_ONDEM];
          diag_r <= pwdata_i[BIS_C_DIAG];
        end
        BIS_A_PRE: pre_r <= pwdata_i[BIS_TW-1:0];
        BIS_A_IGN: ign_r <= pwdata_i[BIS_TW-1:0];
        BIS_A_PRG: prg_r <= pwdata_i[BIS_TW-1:0];
        BIS_A_WAIT: wait_r <= pwdata_i[BIS_TW-1:0];
        BIS_A_PEST: pest_r <= pwdata_i[BIS_TW-1:0];
        BIS_A_RTRY: begin
          irty_cfg_r <= pwdata_i[BIS_RW-1:0];
          wrty_cfg_r <= pwdata_i[BIS_RW+15:16];
        end
        default: ;
      endcase
    end
  end

  logic hit;
  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      BIS_A_CTRL, BIS_A_PRE, BIS_A_IGN, BIS_A_PRG, BIS_A_WAIT, BIS_A_PEST,
      BIS_A_RTRY, BIS_A_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i && penable_i && !hit;

  // one-second tick and timer
  logic [31:0] div_r;
  logic tick;
  assign tick = (div_r == 32'(TICK_CYC - 1));
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) div_r <= 32'h0;
    else if (tick) div_r <= 32'h0;
    else div_r <= div_r + 32'h1;
  end

  bis_state_t st_r, st_nxt;
  logic [BIS_TW-1:0] tmr_r;
  logic [BIS_RW-1:0] irty_r, wrty_r;
  logic [15:0] okcnt_r;
  logic ok_q_r, ok_long_r;
  logic ok_rel, tdone, entry;
  assign ok_rel = ok_q_r && !ok && ok_long_r;
  assign tdone = (tmr_r == '0);
  assign entry = (st_nxt != st_r);

  // ok hold qualification (whole seconds of ticks)
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ok_q_r <= 1'b0;
      okcnt_r <= 16'h0;
      ok_long_r <= 1'b0;
    end else begin
      ok_q_r <= ok;
      if (!ok || !start_sel_i) begin
        okcnt_r <= 16'h0;
        ok_long_r <= ok && ok_long_r && start_sel_i;
      end else if (tick && !ok_long_r) begin
        okcnt_r <= okcnt_r + 16'h1;
        if (okcnt_r + 16'h1 > 16'(BIS_OKHOLD_S)) ok_long_r <= 1'b1;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      BIS_STOP: if (ok_rel) st_nxt = ondem_r ? BIS_IDLE : BIS_START;
      BIS_START: st_nxt = poc ? BIS_POCF : BIS_PRE;
      BIS_PRE: if (tdone) st_nxt = BIS_IGN;
      BIS_IGN: begin
        if (flame) st_nxt = BIS_PEST;
        else if (tdone) st_nxt = BIS_PRG;
      end
      // purge then retry, or go to wait at once when no ignition retries are left
      BIS_PRG: if (irty_r == '0) st_nxt = BIS_WAIT;
               else if (tdone) st_nxt = BIS_IGN;
      // wait then retry, or pilot fault at once when no wait retries are left
      BIS_WAIT: if (wrty_r == '0) st_nxt = BIS_PLTF;
                else if (tdone) st_nxt = BIS_PRE;
      BIS_PEST: if (!flame) st_nxt = BIS_IGN;
                else if (tdone) st_nxt = BIS_PON;
      BIS_PON: if (!flame) st_nxt = BIS_IGN;
               else if (|dem) st_nxt = BIS_ACT;
               else if (ondem_r) st_nxt = BIS_IDLE;
      BIS_ACT: if (!flame) st_nxt = BIS_IGN;
               else if (dem == 3'h0) st_nxt = ondem_r ? BIS_IDLE : BIS_PON;
      BIS_IDLE: if (|dem) st_nxt = BIS_START;
      BIS_POCF, BIS_PLTF: st_nxt = st_r;
      default: st_nxt = BIS_STOP;
    endcase
    // stop key except in alarm states
    if (stop && !alarm_state_i && st_r != BIS_POCF && st_r != BIS_PLTF)
      st_nxt = BIS_STOP;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) st_r <= BIS_STOP;
    else st_r <= st_nxt;
  end

  // shared duration down-counter, reloaded on entry
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) tmr_r <= '0;
    else if (entry) begin
      case (st_nxt)
        BIS_PRE: tmr_r <= pre_r;
        BIS_IGN: tmr_r <= ign_r;
        BIS_PRG: tmr_r <= prg_r;
        BIS_WAIT: tmr_r <= wait_r;
        BIS_PEST: tmr_r <= pest_r;
        default: tmr_r <= '0;
      endcase
    end else if (tick && !tdone) tmr_r <= tmr_r - 1'b1;
  end

  // retry counters
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irty_r <= BIS_IRTY_RST;
      wrty_r <= BIS_WRTY_RST;
    end else begin
      if (entry && st_nxt == BIS_PRE) irty_r <= irty_cfg_r;
      else if (entry && st_nxt == BIS_IGN && st_r != BIS_PRG &&
               st_r != BIS_PRE)
        irty_r <= irty_cfg_r;
      else if (st_r == BIS_PRG && st_nxt == BIS_IGN) irty_r <= irty_r - 1'b1;
      if (st_r == BIS_WAIT && st_nxt == BIS_PRE) wrty_r <= wrty_r - 1'b1;
      else if (entry && st_nxt == BIS_START) wrty_r <= wrty_cfg_r;
    end
  end

  // output drive, registered
  bis_out_t o_nxt;
  always_comb begin
    o_nxt = '0;
    case (st_r)
      BIS_STOP: o_nxt.alarm = 1'b1;
      // ignite opens shutdown and pilot valves
      BIS_IGN: begin
        o_nxt.emergency_shutdown_valve = 1'b1;
        o_nxt.pilot = 1'b1;
        o_nxt.igniter = 1'b1;
      end
      BIS_PEST, BIS_PON: begin
        o_nxt.emergency_shutdown_valve = 1'b1;
        o_nxt.pilot = 1'b1;
      end
      BIS_ACT: begin
        o_nxt.emergency_shutdown_valve = 1'b1;
        o_nxt.pilot = 1'b1;
        o_nxt.prc = dem;
      end
      // valves closed, pilot and igniter off
      BIS_PRG, BIS_WAIT, BIS_IDLE: o_nxt = '0;
      BIS_POCF, BIS_PLTF: o_nxt.alarm = 1'b1;
      default: o_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      outs_o <= '0;
      independent_process_o <= 1'b0;
    end else begin
      outs_o <= o_nxt;
      independent_process_o <= indep && !diag_r;
    end
  end

  assign state_o = st_r;

  // read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) prdata_o <= 32'h0;
    else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        BIS_A_CTRL: prdata_o <= {30'h0, diag_r, ondem_r};
        BIS_A_PRE: prdata_o <= {16'h0, pre_r};
        BIS_A_IGN: prdata_o <= {16'h0, ign_r};
        BIS_A_PRG: prdata_o <= {16'h0, prg_r};
        BIS_A_WAIT: prdata_o <= {16'h0, wait_r};
        BIS_A_PEST: prdata_o <= {16'h0, pest_r};
        BIS_A_RTRY: prdata_o <= {8'h0, wrty_cfg_r, 8'h0, irty_cfg_r};
        BIS_A_STAT: prdata_o <= {tmr_r, wrty_r[3:0], irty_r[3:0],
                                 4'h0, st_r};
        default: prdata_o <= 32'h0;
      endcase
    end
  end
endmodule

// ===== sim/bis_seq_sva.sv
// assertion checker on the sequencer ports
`timescale 1ns/1ns
module bis_seq_sva
  import bis_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset, low
  input wire logic flame_i, // flame pin
  input wire logic closure_proof_input_i, // closure pin
  input wire logic [2:0] demand_i, // demand pins
  input wire logic key_stop_i, // stop key
  input wire logic alarm_state_i, // alarm owner
  input bis_pkg::bis_out_t outs_o, // drives
  input bis_pkg::bis_state_t state_o // state
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rst; $rose(arst_n_i) |-> state_o == BIS_STOP; endproperty
  a_rst: assert property (p_rst) else $error("not stopped");
  property p_stop;
    arst_n_i && state_o == BIS_STOP |=> outs_o.alarm
      && !outs_o.emergency_shutdown_valve && !outs_o.pilot
      && outs_o.prc == 3'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop drive");
  property p_ign;
    state_o == BIS_IGN |=> outs_o.emergency_shutdown_valve && outs_o.pilot
      && outs_o.igniter;
  endproperty
  a_ign: assert property (p_ign) else $error("ignite drive");
  property p_shut;
    state_o inside {BIS_PRG, BIS_WAIT, BIS_IDLE}
      |=> !outs_o.emergency_shutdown_valve && !outs_o.pilot
      && outs_o.prc == 3'h0;
  endproperty
  a_shut: assert property (p_shut) else $error("valves open");
  property p_key;
    (key_stop_i && !alarm_state_i)[*4] ##0
      !(state_o inside {BIS_POCF, BIS_PLTF}) |-> ##[0:2] state_o == BIS_STOP;
  endproperty
  a_key: assert property (p_key) else $error("stop ignored");
  property p_poc;
    (closure_proof_input_i && !key_stop_i)[*4] ##0 state_o == BIS_START
      |=> state_o == BIS_POCF;
  endproperty
  a_poc: assert property (p_poc) else $error("closure missed");
  property p_flm;
    (flame_i && !key_stop_i)[*3] ##0 state_o == BIS_IGN |=> state_o == BIS_PEST;
  endproperty
  a_flm: assert property (p_flm) else $error("flame missed");
  property p_loss;
    (!flame_i && !key_stop_i)[*3] ##0 state_o == BIS_PEST
      |=> state_o == BIS_IGN;
  endproperty
  a_loss: assert property (p_loss) else $error("loss missed");
  property p_act;
    (demand_i != 3'h0 && flame_i && !key_stop_i)[*3] ##0 state_o == BIS_PON
      |=> state_o == BIS_ACT;
  endproperty
  a_act: assert property (p_act) else $error("demand missed");
  property p_prc;
    (demand_i == 3'h5)[*4] ##0 state_o == BIS_ACT |=> outs_o.prc == 3'h5;
  endproperty
  a_prc: assert property (p_prc) else $error("process valves");
  c_act: cover property (state_o == BIS_ACT);
  c_pltf: cover property (state_o == BIS_PLTF);
  c_pocf: cover property (state_o == BIS_POCF);
endmodule
bind bis_sequencer bis_seq_sva bis_seq_sva_i (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .flame_i(flame_i),
  .closure_proof_input_i(closure_proof_input_i),
  .demand_i(demand_i),
  .key_stop_i(key_stop_i),
  .alarm_state_i(alarm_state_i),
  .outs_o(outs_o),
  .state_o(state_o)
);

// ===== sim/bis_plant.sv
// pilot burner and flame sensor model
`timescale 1ns/1ns
module bis_plant
  import bis_pkg::*;
(
  input wire logic clk_i, // clock
  input bis_pkg::bis_out_t outs_i, // valve drive
  input wire logic lit_en_i, // fuel will light
  output logic flame_o // flame sensed
);
  always_ff @(posedge clk_i) begin
    flame_o <= outs_i.pilot && lit_en_i;
  end
endmodule

// ===== sim/tb_burner_ignition_sequencer.sv
// self-checking bench for the burner ignition sequencer
`timescale 1ns/1ns
module tb_burner_ignition_sequencer;
  import bis_pkg::*;
  logic clk_i = 1'h0, arst_n_i = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, flame, indep_o, poc = 1'h0, indep = 1'h0;
  logic ok = 1'h0, stp = 1'h0, ssel = 1'h1, alm = 1'h0, lit = 1'h0;
  logic [2:0] dem = 3'h0;
  bis_out_t outs;
  bis_state_t state;
  int miscompares = 0, comparisons = 0;
  bis_sequencer #(.TICK_CYC(10)) bis_sequencer_i (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .flame_i(flame), .closure_proof_input_i(poc),
    .demand_i(dem), .indep_demand_i(indep), .key_ok_i(ok), .key_stop_i(stp),
    .start_sel_i(ssel), .alarm_state_i(alm), .outs_o(outs),
    .independent_process_o(indep_o), .state_o(state));
  bis_plant bis_plant_i (.clk_i(clk_i), .outs_i(outs), .lit_en_i(lit),
    .flame_o(flame));
  initial forever #5 clk_i = ~clk_i;
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    comparisons++;
    if (!c) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'h1;
    do @(posedge clk_i); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic wst(input bis_state_t s);
    int i;
    for (i = 0; i < 80 && state !== s; i++) @(posedge clk_i);
    chk(state === s, "state not reached");
  endtask
  task automatic rst();
    arst_n_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk(state === BIS_STOP, "reset state");
  endtask
  task automatic go();
    ok <= 1'h1;
    repeat (30) @(posedge clk_i);
    ok <= 1'h0;
  endtask
  task automatic cfg();
    apb(1'h1, BIS_A_PRE, 32'h2);
    apb(1'h1, BIS_A_IGN, 32'h2);
    apb(1'h1, BIS_A_PRG, 32'h1);
    apb(1'h1, BIS_A_WAIT, 32'h1);
    apb(1'h1, BIS_A_PEST, 32'h2);
    apb(1'h1, BIS_A_RTRY, 32'h10001);
  endtask
  task automatic t_regs();
    logic [31:0] ex [7] = '{32'h0, 32'h3c, 32'ha, 32'h1e, 32'h12c, 32'ha,
      32'h30003};
    int i;
    for (i = 0; i < 7; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      chk(rd === ex[i], "reset value");
    end
    apb(1'h0, 8'h20, 32'h0);
    chk(err === 1'h1 && rd === 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_flame();
    cfg();
    lit <= 1'h1;
    go();
    wst(BIS_START);
    wst(BIS_PRE);
    wst(BIS_IGN);
    @(posedge clk_i);
    chk({outs.emergency_shutdown_valve, outs.pilot,
      outs.igniter} === 3'h7, "ignite");
    wst(BIS_PEST);
    lit <= 1'h0;
    wst(BIS_IGN);
    lit <= 1'h1;
    wst(BIS_PEST);
    wst(BIS_PON);
    dem <= 3'h5;
    wst(BIS_ACT);
    repeat (3) @(posedge clk_i);
    chk(outs.prc === 3'h5 && outs.pilot === 1'h1, "valves");
    dem <= 3'h0;
    wst(BIS_PON);
    lit <= 1'h0;
    wst(BIS_IGN);
    alm <= 1'h1;
    stp <= 1'h1;
    repeat (6) @(posedge clk_i);
    chk(state === BIS_IGN, "stop in alarm");
    alm <= 1'h0;
    wst(BIS_STOP);
    stp <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk(outs.alarm === 1'h1 && outs.pilot === 1'h0, "stopped");
    $display("test flame done");
  endtask
  task automatic t_retry();
    bis_state_t sq [13] = '{BIS_PRE, BIS_IGN, BIS_PRG, BIS_IGN, BIS_PRG,
      BIS_WAIT, BIS_PRE, BIS_IGN, BIS_PRG, BIS_IGN, BIS_PRG, BIS_WAIT,
      BIS_PLTF};
    int i;
    go();
    for (i = 0; i < 13; i++) wst(sq[i]);
    stp <= 1'h1;
    indep <= 1'h1;
    repeat (6) @(posedge clk_i);
    chk(state === BIS_PLTF, "stop in failure");
    chk(indep_o === 1'h1, "independent on");
    stp <= 1'h0;
    apb(1'h1, BIS_A_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(indep_o === 1'h0, "diagnostic");
    $display("test retry done");
  endtask
  task automatic t_poc();
    ok <= 1'h1;
    repeat (5) @(posedge clk_i);
    ok <= 1'h0;
    ssel <= 1'h0;
    repeat (10) @(posedge clk_i);
    chk(state === BIS_STOP, "short press");
    go();
    repeat (10) @(posedge clk_i);
    chk(state === BIS_STOP, "entry not selected");
    ssel <= 1'h1;
    poc <= 1'h1;
    go();
    wst(BIS_POCF);
    poc <= 1'h0;
    $display("test closure done");
  endtask
  task automatic t_ondem();
    cfg();
    apb(1'h1, BIS_A_CTRL, 32'h1);
    lit <= 1'h1;
    go();
    wst(BIS_IDLE);
    repeat (20) @(posedge clk_i);
    chk(state === BIS_IDLE && outs.pilot === 1'h0, "idle");
    dem <= 3'h2;
    wst(BIS_START);
    wst(BIS_IGN);
    wst(BIS_ACT);
    dem <= 3'h0;
    wst(BIS_IDLE);
    repeat (2) @(posedge clk_i);
    chk({outs.pilot, outs.emergency_shutdown_valve} === 2'h0, "pilot out");
    $display("test demand done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("CHECK FAILED %0t watchdog", $time);
    complete_run();
  end
  initial begin
    rst();
    t_regs();
    t_flame();
    t_retry();
    rst();
    t_poc();
    rst();
    t_ondem();
    complete_run();
  end
endmodule
